//--- rtl/idle_ctrl_params.svh
// Offsets, field positions, reset values and timing counts of the idle block.
`ifndef IDLE_CTRL_PARAMS_SVH
`define IDLE_CTRL_PARAMS_SVH
`define CTRL_ADDR 4'h0
`define FREQ_ADDR 4'h4
`define STATUS_ADDR 4'h8
`define CMD_ADDR 4'hC
`define CTRL_RESET 32'h0000_0000
`define FREQ_RESET 32'h0000_0000
`define CTRL_IDLE_EN_BIT 0
`define CTRL_SEL0_BIT 1
`define CTRL_SEL1_BIT 2
`define CTRL_SRC_BIT 3
`define CTRL_MFIO_BIT 4
`define CTRL_WATCHDOG_BIT 5
`define CTRL_FSCM_BIT 6
`define CMD_SLEEP_BIT 0
`define CMD_WAKE_BIT 1
`define STAB_TIME_NS 2000
`define SWITCH_TIME_NS 200
`define CLK_PERIOD_NS 40
`define STAB_CYCLES ((`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_CYCLES ((`SWITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- rtl/idle_ctrl_pkg.sv
// Types shared by the idle clock control block.
package idle_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01,
    ST_WAKE = 2'b11
  } power_state_e;
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic hf_osc_en;
    logic lf_osc_en;
    logic primary_osc_en;
  } clock_gate_s;
endpackage : idle_ctrl_pkg

//--- rtl/idle_ctrl.sv
// Idle mode clock control with an AXI4-Lite register slave.
`include "idle_ctrl_params.svh"
module idle_ctrl
  import idle_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_in,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic hf_osc_en_out,
  output logic lf_osc_en_out,
  output logic primary_osc_en_out
);
  // ****************************************
  // Register state.
  // ****************************************
  logic [6:0] ctrl_r;
  logic [2:0] freq_r;
  logic ost_r;
  logic hf_stable_r;
  logic mf_stable_r;
  logic [6:0] stab_cnt_r;
  logic [3:0] sw_cnt_r;
  logic wake_meta_r;
  logic wake_sync_r;
  power_state_e state_r;
  clock_gate_s gate_r;
  logic [3:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic wr_fire;
  logic sleep_cmd;
  logic wake_cmd;
  logic hf_req;
  logic [6:0] ctrl_nxt;
  logic [2:0] freq_nxt;
  logic wake_event;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  clock_gate_s gate_nxt;
  localparam logic [6:0] STAB_N = 7'(`STAB_CYCLES);
  localparam logic [3:0] SWITCH_N = 4'(`SWITCH_CYCLES);

  // ****************************************
  // Register address decode.
  // ****************************************
  function automatic logic addr_mapped(input logic [3:0] addr);
    addr_mapped = (addr == `CTRL_ADDR) || (addr == `FREQ_ADDR) ||
                  (addr == `STATUS_ADDR) || (addr == `CMD_ADDR);
  endfunction : addr_mapped

  // ****************************************
  // AXI4-Lite write channel.
  // ****************************************
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_have_r <= 1'b0;
      awaddr_r <= 4'h0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_mapped(awaddr_r) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  assign sleep_cmd = wr_fire && awaddr_r == `CMD_ADDR && wstrb_r[0] &&
                     wdata_r[`CMD_SLEEP_BIT];
  assign wake_cmd = wr_fire && awaddr_r == `CMD_ADDR && wstrb_r[0] &&
                    wdata_r[`CMD_WAKE_BIT];

  // ****************************************
  // Control registers; wake never touches them.
  // ****************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    freq_nxt = freq_r;
    if (wr_fire && wstrb_r[0] && awaddr_r == `CTRL_ADDR) begin
      ctrl_nxt = wdata_r[6:0];
    end
    if (wr_fire && wstrb_r[0] && awaddr_r == `FREQ_ADDR) begin
      freq_nxt = wdata_r[2:0];
    end
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= 7'(`CTRL_RESET);
      freq_r <= 3'(`FREQ_RESET);
    end else begin
      ctrl_r <= ctrl_nxt;
      freq_r <= freq_nxt;
    end
  end

  // ****************************************
  // Wake input synchroniser.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_meta_r <= 1'b0;
      wake_sync_r <= 1'b0;
    end else begin
      wake_meta_r <= wake_in;
      wake_sync_r <= wake_meta_r;
    end
  end

  // ****************************************
  // Wake sources, pin or software command.
  // ****************************************
  assign wake_event = wake_sync_r || wake_cmd;

  // ****************************************
  // Power state machine.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          // Select bit 0 takes no part in this choice.
          if (sleep_cmd && ctrl_r[`CTRL_IDLE_EN_BIT] &&
              ctrl_r[`CTRL_SEL1_BIT]) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (wake_event) begin
            state_r <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (sw_cnt_r >= SWITCH_N - 4'h1) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // Clock switch delay after a wake event.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_cnt_r <= 4'h0;
    end else if (state_r != ST_WAKE) begin
      sw_cnt_r <= 4'h0;
    end else if (sw_cnt_r < SWITCH_N - 4'h1) begin
      sw_cnt_r <= sw_cnt_r + 4'h1;
    end
  end

  // ****************************************
  // Internal oscillator request.
  // ****************************************
  assign hf_req = (freq_r != 3'h0) || ctrl_r[`CTRL_SRC_BIT] ||
                  ctrl_r[`CTRL_MFIO_BIT];

  // ****************************************
  // Stabilization counter.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stab_cnt_r <= 7'h00;
    end else if (!hf_req) begin
      stab_cnt_r <= 7'h00;
    end else if (stab_cnt_r < STAB_N) begin
      stab_cnt_r <= stab_cnt_r + 7'h01;
    end
  end

  // ****************************************
  // Stable flags.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hf_stable_r <= 1'b0;
    end else if (!hf_req) begin
      hf_stable_r <= 1'b0;
    end else if (stab_cnt_r == STAB_N) begin
      // Once stable, sleep does not restart the count.
      hf_stable_r <= !ctrl_r[`CTRL_MFIO_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mf_stable_r <= 1'b0;
    end else if (!hf_req) begin
      mf_stable_r <= 1'b0;
    end else if (stab_cnt_r == STAB_N) begin
      mf_stable_r <= ctrl_r[`CTRL_MFIO_BIT];
    end
  end

  // ****************************************
  // Primary oscillator status.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ost_r <= 1'b1;
    end else if (ctrl_r[`CTRL_SEL1_BIT]) begin
      ost_r <= 1'b0;
    end else begin
      ost_r <= 1'b1;
    end
  end

  // ****************************************
  // Next clock gate values.
  // ****************************************
  always_comb begin
    gate_nxt.cpu_clk_en = (state_r == ST_RUN);
    gate_nxt.periph_clk_en = 1'b1;
    gate_nxt.hf_osc_en = hf_req;
    gate_nxt.lf_osc_en = ctrl_r[`CTRL_WATCHDOG_BIT] ||
                         ctrl_r[`CTRL_FSCM_BIT];
    gate_nxt.primary_osc_en = !ctrl_r[`CTRL_SEL1_BIT];
  end

  // ****************************************
  // Clock gates, all registered.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gate_r <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    end else begin
      gate_r <= gate_nxt;
    end
  end
  assign cpu_clk_en_out = gate_r.cpu_clk_en;
  assign periph_clk_en_out = gate_r.periph_clk_en;
  assign hf_osc_en_out = gate_r.hf_osc_en;
  assign lf_osc_en_out = gate_r.lf_osc_en;
  assign primary_osc_en_out = gate_r.primary_osc_en;

  // ****************************************
  // Read data selection.
  // ****************************************
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = 2'b00;
    case (s_axi_araddr)
      `CTRL_ADDR: rdata_nxt = {25'h0, ctrl_r};
      `FREQ_ADDR: rdata_nxt = {29'h0, freq_r};
      `STATUS_ADDR: rdata_nxt = {27'h0, state_r, mf_stable_r,
                                 hf_stable_r, ost_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
    if (!addr_mapped(s_axi_araddr)) begin
      rresp_nxt = 2'b10;
    end
  end

  // ****************************************
  // AXI4-Lite read channel.
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : idle_ctrl

//--- testbench/idle_ctrl_asserts.sv
// Port assertions for the idle clock control block.
module idle_ctrl_asserts (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_in,
  input wire logic cpu_clk_en_out,
  input wire logic periph_clk_en_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_periph_on:
    assert property (periph_clk_en_out) else $error("Peripheral clock off.");
  chk_cpu_off:
    assert property ($fell(cpu_clk_en_out) |-> !cpu_clk_en_out [*3])
    else $error("CPU clock back too soon.");
  chk_wake_delay:
    assert property ($rose(wake_in) && !cpu_clk_en_out |->
      !cpu_clk_en_out [*6] ##[1:10] cpu_clk_en_out)
    else $error("Wake delay wrong.");
  chk_wr_latency:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("No response.");
  chk_wr_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("Response dropped.");
  chk_rd_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late.");
  chk_rd_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped.");
  chk_ar_gate:
    assert property (s_axi_arready == !s_axi_rvalid)
    else $error("Read address ready wrong.");
endmodule : idle_ctrl_asserts
bind idle_ctrl idle_ctrl_asserts u_chk (.sys_clk_in, .rst_in, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .wake_in, .cpu_clk_en_out,
  .periph_clk_en_out);

//--- testbench/idle_wake_source.sv
// Outside wake event source, unrelated in phase to the system clock.
module idle_wake_source (
  input wire logic req_in,
  output logic wake_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial wake_out = 1'b0;
  always @(req_in) wake_out <= #13 req_in;
endmodule : idle_wake_source

//--- testbench/idle_ctrl_tb.sv
// Register level testbench of the idle clock control block.
`include "idle_ctrl_params.svh"
module idle_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, awv, wv, bre, arv, rre, req, wake, stall;
  logic awr, wr_r, bv, arr, rv, cpu, per, hf, lf, pri;
  logic [3:0] awa, ara;
  logic [31:0] wd, rdat, rdv;
  logic [1:0] br, rr, resp;
  logic [31:0] c;
  int fail_count, num_checks, n;
  idle_ctrl uut (.sys_clk_in(clk), .rst_in(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .wake_in(wake), .cpu_clk_en_out(cpu),
    .periph_clk_en_out(per), .hf_osc_en_out(hf), .lf_osc_en_out(lf),
    .primary_osc_en_out(pri));
  idle_wake_source u_wake (.req_in(req), .wake_out(wake));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= !stall;
    repeat (30) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv && bre) begin
        bre <= 1'b0; resp = br; break;
      end
      bre <= 1'b1;
    end
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= !stall;
    repeat (30) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rre) begin
        rre <= 1'b0; rdv = rdat; resp = rr; break;
      end
      rre <= 1'b1;
    end
  endtask : rd
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
  initial begin
    rst = 1'b1; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; req = 0;
    awa = 0; ara = 0; wd = 0; stall = 1; fail_count = 0; num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`STATUS_ADDR); check(rdv, 32'h1);
    check(32'({cpu, per, hf, lf, pri}), 32'h19);
    rd(4'h6); check(32'(resp), 32'h2);
    wr(4'h6, 32'h1); check(32'(resp), 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(`CTRL_ADDR, 32'(i) << 5);
      repeat (2) @(posedge clk);
      check(32'(lf), 32'(i != 0));
    end
    stall = 0;
    for (int i = 0; i < 3; i++) begin
      c = (i == 1) ? 32'h8 : (i == 2) ? 32'h10 : 32'h0;
      wr(`CTRL_ADDR, c); wr(`FREQ_ADDR, 32'(i == 0));
      rd(`STATUS_ADDR); check(32'(rdv[2:1]), 32'h0);
      check(32'(hf), 32'h1);
      repeat (60) @(posedge clk);
      rd(`STATUS_ADDR); check(32'(rdv[2:1]), (i == 2) ? 32'h2 : 32'h1);
      wr(`CTRL_ADDR, 32'h0); wr(`FREQ_ADDR, 32'h0);
      rd(`STATUS_ADDR); check(32'({hf, rdv[2:1]}), 32'h0);
    end
    wr(`FREQ_ADDR, 32'h2); repeat (60) @(posedge clk);
    wr(`CTRL_ADDR, 32'h3); wr(`CMD_ADDR, 32'h1); repeat (5) @(posedge clk);
    check(32'(cpu), 32'h1);
    wr(`CTRL_ADDR, 32'h1); wr(`CTRL_ADDR, 32'h7);
    repeat (2) @(posedge clk); check(32'(pri), 32'h0);
    wr(`CMD_ADDR, 32'h1); repeat (4) @(posedge clk);
    check(32'({cpu, per}), 32'h1);
    rd(`STATUS_ADDR); check(rdv, 32'hA);
    @(posedge clk); req <= 1'b1; n = 0;
    while (cpu !== 1'b1 && n < 40) begin
      @(posedge clk); n++;
    end
    check(32'(n >= 7 && n < 40), 32'h1);
    req <= 1'b0;
    rd(`CTRL_ADDR); check(rdv, 32'h7);
    rd(`STATUS_ADDR); check(rdv, 32'h2);
    wr(`CMD_ADDR, 32'h1); repeat (2) @(posedge clk);
    check(32'(cpu), 32'h0);
    wr(`CMD_ADDR, 32'h2); repeat (10) @(posedge clk);
    check(32'(cpu), 32'h1);
    end_of_test;
  end
endmodule : idle_ctrl_tb
